// ### rtl/dct_pkg.sv
// Shared constants of the four-channel DMA control and trigger block
package dct_pkg;
   // Number of channels and widths
   localparam int unsigned NUM_CH   = 4;
   localparam int unsigned CNT_W    = 16;
   localparam int unsigned ADR_W    = 26;
   localparam int unsigned SRC_W    = 48;
   localparam int unsigned PADDR_W  = 12;
   // Per-channel register window: stride and word offsets
   localparam logic [11:0] CH_STRIDE   = 12'h020;
   localparam logic [2:0]  REG_CTRL    = 3'h0;
   localparam logic [2:0]  REG_TRIG    = 3'h1;
   localparam logic [2:0]  REG_ADC     = 3'h2;
   localparam logic [2:0]  REG_COUNT   = 3'h3;
   localparam logic [2:0]  REG_ADDR    = 3'h4;
   localparam logic [2:0]  REG_LAST    = 3'h4;
   // Channel control fields
   localparam int unsigned CTL_EN_BIT   = 0;
   localparam int unsigned CTL_SW_BIT   = 1;
   localparam int unsigned CTL_INIT_BIT = 2;
   localparam int unsigned CTL_DONE_BIT = 7;
   localparam logic [7:0]  CTL_RESET    = 8'h00;
   // Trigger select fields
   localparam int unsigned TRG_PEND_BIT = 7;
   localparam logic [5:0]  TRG_CODE_OFF = 6'h00;
   localparam logic [5:0]  TRG_CODE_MAX = 6'h30;
   localparam logic [7:0]  TRG_RESET    = 8'h00;
   // Addressing control fields
   localparam int unsigned ADC_SIZE_BIT = 14;
   localparam int unsigned ADC_SDIR_HI  = 7;
   localparam int unsigned ADC_SDIR_LO  = 6;
   localparam logic [15:0] ADC_MASK     = 16'h40F0;
   localparam logic [15:0] ADC_RESET    = 16'h0000;
   // Source address direction codes
   localparam logic [1:0]  DIR_INC      = 2'h0;
   localparam logic [1:0]  DIR_DEC      = 2'h1;
   localparam logic [1:0]  DIR_FIXED    = 2'h2;
endpackage : dct_pkg

// ### rtl/dct_apb.sv
`timescale 1ns/1ps
// APB slave front end: no wait state, registered answer
module dct_apb (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] rd_value,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [1:0]       dec_chan,
   output logic [2:0]       dec_reg,
   output logic             wr_stb,
   output logic             rd_done_clr
);
   logic        setup;      // Setup phase of a transfer
   logic        access;     // Completing access edge
   logic        bad;        // Address outside the map
   logic        pready_ff;  // Ready flop
   logic        pslverr_ff; // Error flop
   logic [31:0] prdata_ff;  // Read data flop

   // Address decode, held stable by the master through access
   assign dec_chan = paddr[6:5];
   assign dec_reg  = paddr[4:2];
   assign bad      = (paddr[11:7] != 5'h00) || (dec_reg > dct_pkg::REG_LAST);
   assign setup    = psel & ~penable;
   assign access   = psel & penable & pready_ff;

   // Ready rises for the access phase right after setup
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
      end
   end

   // Unmapped address answers with an error
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= setup & bad;
      end
   end

   // Read data captured at setup, zero for writes and errors
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup && !pwrite && !bad) begin
         prdata_ff <= rd_value;
      end else if (setup) begin
         prdata_ff <= 32'h0000_0000;
      end
   end

   // Strobes act only at the completing edge
   assign wr_stb      = access & pwrite & ~pslverr_ff;
   assign rd_done_clr = access & ~pwrite & ~pslverr_ff &
                        (dec_reg == dct_pkg::REG_CTRL) &
                        prdata_ff[dct_pkg::CTL_DONE_BIT];
   assign prdata      = prdata_ff;
   assign pready      = pready_ff;
   assign pslverr     = pslverr_ff;
endmodule : dct_apb

// ### rtl/dct_dma_ctl.sv
`timescale 1ns/1ps
module dct_dma_ctl #(
   parameter int unsigned NUM_CH = dct_pkg::NUM_CH,
   parameter int unsigned SRC_W  = dct_pkg::SRC_W
) (
   input  wire logic                                clk_sys,
   input  wire logic                                rst_n,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [dct_pkg::PADDR_W-1:0]         paddr,
   input  wire logic [31:0]                         pwdata,
   output logic [31:0]                              prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire logic [SRC_W-1:0]                    periph_irq,
   input  wire logic                                standby_mode,
   input  wire logic [NUM_CH-1:0]                   xfer_ack,
   output logic [NUM_CH-1:0]                        xfer_req,
   output logic [NUM_CH-1:0]                        xfer_wide,
   output logic [NUM_CH-1:0][dct_pkg::ADR_W-1:0]    xfer_addr,
   output logic [NUM_CH-1:0]                        completion_irq
);
   // Decoded bus access
   logic [1:0]  dec_chan;     // Channel of the access
   logic [2:0]  dec_reg;      // Register of the access
   logic        wr_stb;       // Write takes effect
   logic        rd_done_clr;  // Read saw done set
   logic [31:0] rd_value;     // Read mux output

   // Per-channel state
   logic                      en_ff    [NUM_CH]; // Channel enable
   logic                      done_ff  [NUM_CH]; // Completion flag
   logic                      pend_ff  [NUM_CH]; // Latched hw request
   logic                      busy_ff  [NUM_CH]; // Transfer outstanding
   logic                      term_ff  [NUM_CH]; // Terminal seen last edge
   logic [5:0]                code_ff  [NUM_CH]; // Trigger source code
   logic [15:0]               adc_ff   [NUM_CH]; // Addressing control
   logic [dct_pkg::CNT_W-1:0] cbase_ff [NUM_CH]; // Programmed count
   logic [dct_pkg::CNT_W-1:0] cnt_ff   [NUM_CH]; // Remaining count
   logic [dct_pkg::ADR_W-1:0] abase_ff [NUM_CH]; // Programmed address
   logic [dct_pkg::ADR_W-1:0] addr_ff  [NUM_CH]; // Current address

   // Output flops
   logic [NUM_CH-1:0]                     req_ff;   // Request to far side
   logic [NUM_CH-1:0]                     wide_ff;  // Item size of request
   logic [NUM_CH-1:0][dct_pkg::ADR_W-1:0] xaddr_ff; // Aligned address
   logic [NUM_CH-1:0]                     irq_ff;   // Completion pulse

   // Bus slave: decode, ready, error and read data
   dct_apb u_apb (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .rd_value    (rd_value),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .dec_chan    (dec_chan),
      .dec_reg     (dec_reg),
      .wr_stb      (wr_stb),
      .rd_done_clr (rd_done_clr)
   );

   // Read mux; write-only bits and reserved bits read zero
   always_comb begin
      rd_value = 32'h0000_0000;
      unique case (dec_reg)
         dct_pkg::REG_CTRL: begin
            rd_value[dct_pkg::CTL_DONE_BIT] = done_ff[dec_chan];
            rd_value[dct_pkg::CTL_EN_BIT]   = en_ff[dec_chan];
         end
         dct_pkg::REG_TRIG: begin
            rd_value[5:0] = code_ff[dec_chan];
         end
         dct_pkg::REG_ADC: begin
            rd_value[15:0] = adc_ff[dec_chan];
         end
         dct_pkg::REG_COUNT: begin
            rd_value[dct_pkg::CNT_W-1:0] = cnt_ff[dec_chan];
         end
         dct_pkg::REG_ADDR: begin
            rd_value[dct_pkg::ADR_W-1:0] = addr_ff[dec_chan];
         end
         default: begin
            rd_value = 32'h0000_0000;
         end
      endcase
   end

   // One copy of the channel logic per channel
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic sel;      // Access targets this channel
      logic wr_ctrl;  // Control register write
      logic wr_trig;  // Trigger select write
      logic init;     // Channel initialise request
      logic sw_go;    // Software trigger written
      logic src_hit;  // Selected source fired
      logic go;       // Start one transfer
      logic step;     // Transfer finished
      logic borrow;   // Last transfer finished
      logic [5:0]                idx;  // Source bit index
      logic [dct_pkg::ADR_W-1:0] inc;  // Address step

      assign sel     = (dec_chan == 2'(c));
      assign wr_ctrl = wr_stb & sel & (dec_reg == dct_pkg::REG_CTRL);
      assign wr_trig = wr_stb & sel & (dec_reg == dct_pkg::REG_TRIG);
      // Only a written 1 acts; a 0 is ignored
      assign init    = wr_ctrl & pwdata[dct_pkg::CTL_INIT_BIT] & ~en_ff[c];
      assign sw_go   = wr_ctrl & pwdata[dct_pkg::CTL_SW_BIT];
      assign idx     = code_ff[c] - 6'h01;
      // Code zero or past the last source selects nothing
      assign src_hit = (code_ff[c] != dct_pkg::TRG_CODE_OFF) &&
                       (code_ff[c] <= dct_pkg::TRG_CODE_MAX) &&
                       periph_irq[idx];
      // Start needs enable, no completion and nothing in flight
      assign go      = en_ff[c] & ~done_ff[c] & ~busy_ff[c] &
                       (sw_go | pend_ff[c]);
      assign step    = xfer_ack[c] & busy_ff[c];
      assign borrow  = step & (cnt_ff[c] == '0);
      assign inc     = adc_ff[c][dct_pkg::ADC_SIZE_BIT] ?
                       dct_pkg::ADR_W'(2) : dct_pkg::ADR_W'(1);

      // Enable: software sets and clears, terminal count clears
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            en_ff[c] <= dct_pkg::CTL_RESET[dct_pkg::CTL_EN_BIT];
         end else if (borrow) begin
            en_ff[c] <= 1'b0;
         end else if (wr_ctrl) begin
            en_ff[c] <= pwdata[dct_pkg::CTL_EN_BIT];
         end
      end

      // Terminal marker delays done by one edge
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            term_ff[c] <= 1'b0;
         end else begin
            term_ff[c] <= borrow;
         end
      end

      // Done flag: set after enable falls, read or init clears
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            done_ff[c] <= dct_pkg::CTL_RESET[dct_pkg::CTL_DONE_BIT];
         end else if (term_ff[c]) begin
            done_ff[c] <= 1'b1;
         end else if ((rd_done_clr && sel) || init) begin
            done_ff[c] <= 1'b0;
         end
      end

      // Completion pulse rises with the done flag
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            irq_ff[c] <= 1'b0;
         end else begin
            irq_ff[c] <= term_ff[c];
         end
      end

      // Pending request: standby blocks, start consumes
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            pend_ff[c] <= dct_pkg::TRG_RESET[dct_pkg::TRG_PEND_BIT];
         end else if (go && pend_ff[c]) begin
            pend_ff[c] <= 1'b0;
         end else if (src_hit && !standby_mode) begin
            pend_ff[c] <= 1'b1;
         end else if (wr_trig && !pwdata[dct_pkg::TRG_PEND_BIT]) begin
            pend_ff[c] <= 1'b0;
         end else if (init) begin
            pend_ff[c] <= 1'b0;
         end
      end

      // Trigger source code
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            code_ff[c] <= dct_pkg::TRG_RESET[5:0];
         end else if (wr_trig) begin
            code_ff[c] <= pwdata[5:0];
         end
      end

      // Addressing control; reserved bits stored as zero
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            adc_ff[c] <= dct_pkg::ADC_RESET;
         end else if (wr_stb && sel && dec_reg == dct_pkg::REG_ADC) begin
            adc_ff[c] <= pwdata[15:0] & dct_pkg::ADC_MASK;
         end
      end

      // Count: programmed value and remaining value
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            cbase_ff[c] <= '0;
            cnt_ff[c]   <= '0;
         end else if (wr_stb && sel && dec_reg == dct_pkg::REG_COUNT) begin
            cbase_ff[c] <= pwdata[dct_pkg::CNT_W-1:0];
            cnt_ff[c]   <= pwdata[dct_pkg::CNT_W-1:0];
         end else if (init || borrow) begin
            cnt_ff[c] <= cbase_ff[c];
         end else if (step) begin
            cnt_ff[c] <= cnt_ff[c] - 1'b1;
         end
      end

      // Source address walks by item size per direction
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            abase_ff[c] <= '0;
            addr_ff[c]  <= '0;
         end else if (wr_stb && sel && dec_reg == dct_pkg::REG_ADDR) begin
            abase_ff[c] <= pwdata[dct_pkg::ADR_W-1:0];
            addr_ff[c]  <= pwdata[dct_pkg::ADR_W-1:0];
         end else if (init || borrow) begin
            addr_ff[c] <= abase_ff[c];
         end else if (step) begin
            unique case (adc_ff[c][dct_pkg::ADC_SDIR_HI:dct_pkg::ADC_SDIR_LO])
               dct_pkg::DIR_INC: begin
                  addr_ff[c] <= addr_ff[c] + inc;
               end
               dct_pkg::DIR_DEC: begin
                  addr_ff[c] <= addr_ff[c] - inc;
               end
               default: begin
                  addr_ff[c] <= addr_ff[c];
               end
            endcase
         end
      end

      // Busy and request: held until the far side acks or an init write clears them
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            busy_ff[c] <= 1'b0;
            req_ff[c]  <= 1'b0;
         end else if (init) begin
            busy_ff[c] <= 1'b0;
            req_ff[c]  <= 1'b0;
         end else if (go) begin
            busy_ff[c] <= 1'b1;
            req_ff[c]  <= 1'b1;
         end else if (step) begin
            busy_ff[c] <= 1'b0;
            req_ff[c]  <= 1'b0;
         end
      end

      // Item size and aligned address frozen at start
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            wide_ff[c]  <= 1'b0;
            xaddr_ff[c] <= '0;
         end else if (go) begin
            wide_ff[c]  <= adc_ff[c][dct_pkg::ADC_SIZE_BIT];
            xaddr_ff[c] <= {addr_ff[c][dct_pkg::ADR_W-1:1],
                            addr_ff[c][0] & ~adc_ff[c][dct_pkg::ADC_SIZE_BIT]};
         end
      end
   end

   // Outputs straight from flops
   assign xfer_req       = req_ff;
   assign xfer_wide      = wide_ff;
   assign xfer_addr      = xaddr_ff;
   assign completion_irq = irq_ff;
endmodule : dct_dma_ctl

// ### dv/dct_dma_ctl_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the channel control block
module dct_dma_ctl_chk #(
   parameter int unsigned NUM_CH = 4,
   parameter int unsigned SRC_W  = 48
) (
   input wire logic                                 clk_sys,
   input wire logic                                 rst_n,
   input wire logic                                 psel,
   input wire logic                                 penable,
   input wire logic                                 pwrite,
   input wire logic [dct_pkg::PADDR_W-1:0]          paddr,
   input wire logic [31:0]                          pwdata,
   input wire logic [31:0]                          prdata,
   input wire logic                                 pready,
   input wire logic                                 pslverr,
   input wire logic [SRC_W-1:0]                     periph_irq,
   input wire logic                                 standby_mode,
   input wire logic [NUM_CH-1:0]                    xfer_ack,
   input wire logic [NUM_CH-1:0]                    xfer_req,
   input wire logic [NUM_CH-1:0]                    xfer_wide,
   input wire logic [NUM_CH-1:0][dct_pkg::ADR_W-1:0] xfer_addr,
   input wire logic [NUM_CH-1:0]                    completion_irq
);
   logic [NUM_CH-1:0] addr_lsb;  // Bit 0 of each start address
   // Gather address bit 0 of every channel
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         addr_lsb[i] = xfer_addr[i][0];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Setup phase of an APB transfer
   sequence setup_s;
      psel && !penable;
   endsequence
   // Answered read of a control register
   sequence ctrl_rd_s;
      pready && !pwrite && paddr[11:7] == 5'h00 && paddr[4:0] == 5'h00;
   endsequence
   // Acknowledged transfer on channel 0
   sequence ack_s;
      xfer_req[0] && xfer_ack[0];
   endsequence
   apb_answer_a: assert property (setup_s |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   pulse_bits_a: assert property (ctrl_rd_s |->
      prdata[6:1] == 6'h00 && prdata[31:8] == 24'h0)
      else $error("control read shows write-only or unused bits");
   unmapped_a: assert property (pready && paddr[11:7] != 5'h00 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   irq_pulse_a: assert property ((completion_irq & $past(completion_irq)) == '0)
      else $error("completion pulse longer than one cycle");
   req_hold_a: assert property (xfer_req[0] && !xfer_ack[0] |=>
      xfer_req[0] && $stable(xfer_addr[0]) && $stable(xfer_wide[0]))
      else $error("request dropped or changed before ack");
   ack_drop_a: assert property (ack_s |=> !xfer_req[0])
      else $error("request stays after ack");
   wide_even_a: assert property ((xfer_req & xfer_wide & addr_lsb) == '0)
      else $error("wide transfer starts at odd address");
   irq_cause_a: assert property (completion_irq[0] |->
      $past(xfer_req[0] && xfer_ack[0], 2))
      else $error("completion without final ack two cycles before");
   done_idle_a: assert property (completion_irq[0] |-> !xfer_req[0])
      else $error("request active at terminal count");
endmodule : dct_dma_ctl_chk
bind dct_dma_ctl dct_dma_ctl_chk #(.NUM_CH(NUM_CH), .SRC_W(SRC_W)) chk_i (
   .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .periph_irq(periph_irq), .standby_mode(standby_mode), .xfer_ack(xfer_ack),
   .xfer_req(xfer_req), .xfer_wide(xfer_wide), .xfer_addr(xfer_addr),
   .completion_irq(completion_irq));

// ### dv/dct_far_model.sv
`timescale 1ns/1ps
// Far-side bus model: answers each channel request after a set delay
module dct_far_model (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic [3:0] xfer_req,
   input  wire logic [7:0] ack_delay,
   output logic      [3:0] xfer_ack
);
   logic [3:0][7:0] wait_ff;  // Cycles waited per channel
   // One ack pulse per request, given only while the request stands
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff  <= '0;
         xfer_ack <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            xfer_ack[i] <= 1'b0;
            if (!xfer_req[i] || xfer_ack[i]) begin
               wait_ff[i] <= 8'h00;  // Idle or just answered
            end else if (wait_ff[i] >= ack_delay) begin
               xfer_ack[i] <= 1'b1;  // Transfer finished
            end else begin
               wait_ff[i] <= wait_ff[i] + 8'h01;
            end
         end
      end
   end
endmodule : dct_far_model

// ### dv/tb.sv
`timescale 1ns/1ps
// Self-checking bench of the channel control block
module tb;
   logic            clk_sys = 1'b0;
   logic            rst_n = 1'b0;
   logic            psel = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite = 1'b0;
   logic [11:0]     paddr = 12'h000;
   logic [31:0]     pwdata = 32'h0;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic [47:0]     periph_irq = 48'h0;
   logic            standby_mode = 1'b0;
   logic [7:0]      ack_delay = 8'h02;
   logic [3:0]      xfer_ack;
   logic [3:0]      xfer_req;
   logic [3:0]      xfer_wide;
   logic [3:0][25:0] xfer_addr;
   logic [3:0]      completion_irq;
   int              num_errors = 0;
   int              total_checks = 0;
   int              m_en[4] = '{0, 0, 0, 0};    // Model enable per channel
   int              m_done[4] = '{0, 0, 0, 0};  // Model done flag per channel
   // System clock, 25 ns period
   always #12.5 clk_sys = ~clk_sys;
   dct_dma_ctl uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_irq(periph_irq), .standby_mode(standby_mode),
      .xfer_ack(xfer_ack), .xfer_req(xfer_req), .xfer_wide(xfer_wide),
      .xfer_addr(xfer_addr), .completion_irq(completion_irq));
   dct_far_model far (.clk_sys(clk_sys), .rst_n(rst_n), .xfer_req(xfer_req),
      .ack_delay(ack_delay), .xfer_ack(xfer_ack));
   // Prints counts and verdict, then stops
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   // Compares a seen value with the model
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string nm);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, r, x);
   endtask : rdc
   // Register byte address of a channel
   function automatic logic [11:0] ra(input int ch, input int off);
      return 12'(ch * 32 + off);
   endfunction : ra
   // Expected control register from the model
   function automatic logic [31:0] ectl(input int ch);
      return {24'h0, m_done[ch][0], 6'h00, m_en[ch][0]};
   endfunction : ectl
   // Bounded wait for a request or completion pulse
   task automatic wait_hi(input int ch, input bit irq);
      int   n;
      logic v;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         v = irq ? completion_irq[ch] : xfer_req[ch];
      end while (v !== 1'b1 && n < 40);
      chk(irq ? "irq" : "req", v, 32'h1);
      // A wait that ran out ends the run
      if (v !== 1'b1) begin
         wrap_up();
      end
   endtask : wait_hi
   // No request may appear for eight cycles
   task automatic quiet(input int ch);
      repeat (8) begin
         @(posedge clk_sys);
         chk("idle req", xfer_req[ch], 32'h0);
      end
   endtask : quiet
   task automatic pulse(input logic [47:0] v);
      periph_irq <= v;
      @(posedge clk_sys);
      periph_irq <= 48'h0;
      @(posedge clk_sys);
   endtask : pulse
   // Main sequence
   initial begin
      logic [31:0] r;
      logic        e;
      logic [25:0] adr;
      logic [47:0] sel;
      int          code;
      void'($urandom(25));
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int ch = 0; ch < 4; ch++) begin
         rdc(ra(ch, 0), ectl(ch), "ctrl reset");
         rdc(ra(ch, 4), 32'h0, "trig reset");
      end
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, i ? 12'h080 : 12'h014, 32'hFFFFFFFF, r, e);
         chk("wr err", e, 32'h1);
         apb(1'b0, i ? 12'h080 : 12'h014, 32'h0, r, e);
         chk("rd err", {r[30:0], e}, 32'h1);
      end
      wr(ra(0, 0), 32'h06);
      quiet(0);
      rdc(ra(0, 0), ectl(0), "pulse bits");
      adr = 26'($urandom) | 26'h1;
      wr(ra(0, 8), 32'h4000);
      wr(ra(0, 12), 32'h1);
      wr(ra(0, 16), {6'h00, adr});
      wr(ra(0, 0), 32'h01);
      m_en[0] = 1;
      wr(ra(0, 0), 32'h03);
      wait_hi(0, 1'b0);
      chk("wide", xfer_wide[0], 32'h1);
      chk("addr", xfer_addr[0], {6'h00, adr & 26'h3FFFFFE});
      repeat (5) @(posedge clk_sys);
      rdc(ra(0, 12), 32'h0, "count");
      rdc(ra(0, 0), ectl(0), "ctrl busy");
      wr(ra(0, 0), 32'h03);
      wait_hi(0, 1'b1);
      m_en[0] = 0;
      m_done[0] = 1;
      wr(ra(0, 0), 32'h03);
      m_en[0] = 1;
      quiet(0);
      rdc(ra(0, 0), ectl(0), "done");
      m_done[0] = 0;
      rdc(ra(0, 0), ectl(0), "read clear");
      wr(ra(0, 0), 32'h00);
      m_en[0] = 0;
      code = 1 + $urandom % 48;
      sel = 48'h1 << (code - 1);
      wr(ra(2, 12), 32'h0);
      wr(ra(2, 4), 32'(code));
      rdc(ra(2, 4), 32'(code), "code");
      standby_mode <= 1'b1;
      pulse(sel);
      standby_mode <= 1'b0;
      wr(ra(2, 0), 32'h01);
      quiet(2);
      wr(ra(2, 0), 32'h00);
      pulse(~sel);
      wr(ra(2, 0), 32'h01);
      quiet(2);
      wr(ra(2, 0), 32'h00);
      pulse(sel);
      wr(ra(2, 0), 32'h01);
      wait_hi(2, 1'b0);
      wait_hi(2, 1'b1);
      m_done[2] = 1;
      rdc(ra(2, 0), ectl(2), "hw done");
      m_done[2] = 0;
      pulse(sel);
      wr(ra(2, 4), 32'(code));
      wr(ra(2, 0), 32'h01);
      quiet(2);
      wr(ra(2, 0), 32'h00);
      wr(ra(2, 4), 32'h0);
      pulse(48'hFFFFFFFFFFFF);
      wr(ra(2, 0), 32'h01);
      quiet(2);
      wr(ra(2, 0), 32'h00);
      // Channel 3: byte items, source pointer counting down
      ack_delay <= 8'h06;
      wr(ra(3, 8), 32'h0040);
      wr(ra(3, 16), {6'h00, adr});
      wr(ra(3, 12), 32'h2);
      wr(ra(3, 0), 32'h01);
      m_en[3] = 1;
      wr(ra(3, 0), 32'h03);
      wait_hi(3, 1'b0);
      chk("narrow", xfer_wide[3], 32'h0);
      chk("odd addr", xfer_addr[3], {6'h00, adr});
      wr(ra(3, 0), 32'h00);
      m_en[3] = 0;
      repeat (8) @(posedge clk_sys);
      rdc(ra(3, 12), 32'h1, "paused count");
      rdc(ra(3, 16), {6'h00, 26'(adr - 26'h1)}, "dec addr");
      wr(ra(3, 0), 32'h02);
      quiet(3);
      wr(ra(3, 0), 32'h04);
      rdc(ra(3, 12), 32'h2, "init count");
      rdc(ra(3, 16), {6'h00, adr}, "init addr");
      rdc(ra(3, 0), ectl(3), "init ctrl");
      wr(ra(3, 0), 32'h01);
      m_en[3] = 1;
      wr(ra(3, 0), 32'h03);
      wait_hi(3, 1'b0);
      repeat (10) @(posedge clk_sys);
      wr(ra(3, 0), 32'h00);
      m_en[3] = 0;
      wrap_up();
   end
endmodule : tb
